// ### design/amsc_top.sv
// Mode, strap, USB link and DisplayPort lane control with APB registers
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// R1: Host-bus strap at level 0 selects pin control of mode and orientation.
// R2: Alt-mode pin high enables DP; both select pins low powers down.
// R3: Alt low, mode-select-low high: one USB port, flip per orientation.
// R4: Alt high, mode-select-low low: four DP lanes, flip per orientation.
// R5: Both select pins high: USB port plus two DP lanes, flip per pin.
// R6: After power-up USB-only until a mode-select-low transition is seen.
// R7: Controller pulses mode-select-low low-high-low to leave default USB.
// R8: While LFPS is detected, USB receive equalization is off.
// R9: Without LFPS, equalization uses strap gains or programmed gains.
// R10: Receiver detection repeats; found receiver enables termination, redrive.
// R11: USB U-state inferred from termination, idle and LFPS only.
// R12: In DP modes, watch AUX writes to lane count and power state.
// R13: Active DP lanes follow the snooped lane count value.
// R14: Snooped power state D3 disables all DP lanes.
// R15: Snooping on after reset; register bit off uses lane register.
// R16: Pin mode, snoop-disable strap high: no snooping, all four lanes.
// R17: Each four-level input resolves to 0, R, F or 1.
// R18: Straps latch at internal reset release; pulls isolate after hold.
// R19: Each path takes a 16-step gain from its own pin pair.
// R20: Registers may override the equalization gains.
// R21: Alt-mode and hot-plug falling edges debounced 2 to 10 ms.
// R22: Controller overlaps select pins 4 us when swapping USB and DP4.
// R23: Alt high routes AUX straight or crossed; opens after 2 ms low.
// R24: Register control strap takes mode, flip and lanes from registers.
module amsc_top #(
	parameter int DEBOUNCE_CYC = amsc_pkg::DEBOUNCE_CYC,
	parameter int RXDET_CYC = amsc_pkg::RXDET_CYC,
	parameter int U2_IDLE_CYC = amsc_pkg::U2_IDLE_CYC,
	parameter int U3_IDLE_CYC = amsc_pkg::U3_IDLE_CYC
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Control pins
	input wire logic alt_mode_select,
	input wire logic mode_select_low,
	input wire logic plug_flip,
	input wire logic hot_plug_input,
	input wire logic snoop_disable_strap,
	// Resolved four-level straps, two bits per pin
	input wire logic [1:0] host_bus_cfg_strap,
	input wire logic [3:0] rx_gain_pins,
	input wire logic [3:0] usb_path_gain_pins,
	input wire logic [3:0] dp_path_gain_pins,
	output logic strap_pull_enable,
	// USB receiver conditions and controls
	input wire logic lfps_detect,
	input wire logic elec_idle,
	input wire logic rx_detect_result,
	output logic rx_detect_start,
	output logic rx_term_enable,
	output logic redrive_ready,
	output logic usb_eq_enable,
	output logic [3:0] usb_up_gain,
	output logic [3:0] usb_dn_gain,
	output logic [3:0] dp_gain,
	output logic [3:0] usb_power_state,
	// AUX write snoop, from decoder logic on pclk
	input wire logic aux_wr_valid,
	input wire logic [19:0] aux_wr_addr,
	input wire logic [7:0] aux_wr_data,
	// Crosspoint controls
	output logic [3:0] switch_mode,
	output logic switch_flip,
	output logic [3:0] dp_lane_enable,
	output logic aux_to_sb_straight,
	output logic aux_to_sb_crossed,
	output logic hot_plug_level
);
	localparam int NSYNC = 22;
	localparam int CW = amsc_pkg::CNT_W;

	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic alt_s, mode_select_low_s, flip_s, hpd_s, snoop_s, lfps_s, idle_s, rxres_s;
	logic [13:0] straps_s;
	logic [13:0] straps;
	logic [7:0] hold_cnt;
	logic pin_mode;
	logic mode_select_low_q, seen_edge;
	logic [1:0] deb_in;
	logic [1:0] deb_out;
	logic [4:0] ctrl;
	logic [3:0] lanes_reg;
	logic [11:0] gain_reg;
	logic wr_en;
	logic [3:0] next_mode;
	logic next_flip;
	logic dp_mode, usb_mode;
	logic snoop_on;
	logic [4:0] lane_cnt;
	logic d3;
	logic [3:0] next_lanes;
	logic [3:0] cnt_mask;
	logic [CW-1:0] rxdet_cnt;
	logic rx_found;
	logic [CW-1:0] idle_cnt;
	logic [3:0] mode_q;
	logic alt_deb_q;

	// Every pin input crosses two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {dp_path_gain_pins, usb_path_gain_pins, rx_gain_pins,
				host_bus_cfg_strap, rx_detect_result, elec_idle, lfps_detect,
				snoop_disable_strap, hot_plug_input, plug_flip,
				mode_select_low, alt_mode_select};
			sync_b <= sync_a;
		end
	end
	assign {straps_s, rxres_s, idle_s, lfps_s, snoop_s, hpd_s, flip_s,
		mode_select_low_s, alt_s} = sync_b;

	// Four-level codes arrive resolved; latched once then held [R17]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt <= '0;
			straps <= '0;
			strap_pull_enable <= 1'b1;
		end else begin
			if (hold_cnt != 8'(amsc_pkg::STRAP_HOLD_CYC))
				hold_cnt <= hold_cnt + 8'h01;
			if (hold_cnt == 8'(amsc_pkg::STRAP_LATCH_CYC))
				straps <= straps_s; // [R18]
			if (hold_cnt == 8'(amsc_pkg::STRAP_HOLD_CYC))
				strap_pull_enable <= 1'b0; // [R18]
		end
	end
	assign pin_mode = straps[1:0] == amsc_pkg::LVL_0; // [R1]

	// Falling edges wait out the debounce; rising edges act at once
	assign deb_in = {hpd_s, alt_s};
	generate
		for (genvar i = 0; i < 2; i++) begin : g_deb
			logic [CW-1:0] cnt;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt <= '0;
					deb_out[i] <= 1'b0;
				end else if (deb_in[i]) begin
					cnt <= '0;
					deb_out[i] <= 1'b1;
				end else if (deb_out[i]) begin
					if (cnt == CW'(DEBOUNCE_CYC - 1))
						deb_out[i] <= 1'b0; // [R21]
					else
						cnt <= cnt + CW'(1);
				end
			end
		end
	endgenerate

	// Default USB holds until mode_select_low is seen to move
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_select_low_q <= 1'b0;
			seen_edge <= 1'b0;
		end else begin
			mode_select_low_q <= mode_select_low_s;
			if (hold_cnt == 8'(amsc_pkg::STRAP_HOLD_CYC) && mode_select_low_s != mode_select_low_q)
				seen_edge <= 1'b1; // [R6]
		end
	end

	// APB registers; single access cycle, no wait states
	assign wr_en = psel && penable && pwrite && pready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= amsc_pkg::CTRL_RST;
			lanes_reg <= amsc_pkg::LANES_RST;
			gain_reg <= amsc_pkg::GAIN_RST;
		end else if (wr_en) begin
			unique case (paddr)
				amsc_pkg::REG_CTRL: ctrl <= pwdata[4:0];
				amsc_pkg::REG_LANES: lanes_reg <= pwdata[3:0];
				amsc_pkg::REG_GAIN: gain_reg <= pwdata[11:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && !penable) begin
				unique case (paddr)
					amsc_pkg::REG_CTRL: prdata <= {27'h0, ctrl};
					amsc_pkg::REG_LANES: prdata <= {28'h0, lanes_reg};
					amsc_pkg::REG_GAIN: prdata <= {20'h0, gain_reg};
					amsc_pkg::REG_STATUS: prdata <= {15'h0, hot_plug_level,
						pin_mode, lfps_s, rx_found, dp_lane_enable,
						usb_power_state, switch_flip, switch_mode};
					amsc_pkg::REG_STRAPS: prdata <= {18'h0, straps};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Mode decode from pins or from the control register
	always_comb begin
		next_flip = flip_s;
		if (!pin_mode) begin
			next_flip = ctrl[amsc_pkg::CTRL_FLIP]; // [R24]
			unique case (ctrl[amsc_pkg::CTRL_MODE_LSB +: 2])
				2'h0: next_mode = amsc_pkg::MODE_PWRDN;
				2'h1: next_mode = amsc_pkg::MODE_USB;
				2'h2: next_mode = amsc_pkg::MODE_DP4;
				default: next_mode = amsc_pkg::MODE_USB_DP2;
			endcase
		end else if (!seen_edge) begin
			next_mode = amsc_pkg::MODE_USB; // [R6]
		end else begin
			unique case ({deb_out[0], mode_select_low_s})
				2'b00: next_mode = amsc_pkg::MODE_PWRDN; // [R2]
				2'b01: next_mode = amsc_pkg::MODE_USB; // [R3]
				2'b10: next_mode = amsc_pkg::MODE_DP4; // [R4]
				default: next_mode = amsc_pkg::MODE_USB_DP2; // [R5]
			endcase
		end
	end
	assign dp_mode = mode_q[2] || mode_q[3];
	assign usb_mode = mode_q[1] || mode_q[3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= amsc_pkg::MODE_USB;
			switch_mode <= amsc_pkg::MODE_USB;
			switch_flip <= 1'b0;
			hot_plug_level <= 1'b0;
		end else begin
			mode_q <= next_mode;
			switch_mode <= next_mode;
			switch_flip <= next_flip;
			hot_plug_level <= deb_out[1]; // [R21]
		end
	end

	// AUX pair to sideband; opens only after debounced low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_deb_q <= 1'b0;
			aux_to_sb_straight <= 1'b0;
			aux_to_sb_crossed <= 1'b0;
		end else begin
			alt_deb_q <= deb_out[0];
			aux_to_sb_straight <= deb_out[0] && !flip_s; // [R23]
			aux_to_sb_crossed <= deb_out[0] && flip_s; // [R23]
		end
	end

	// Snoop lane count and power state writes in DP modes
	assign snoop_on = !ctrl[amsc_pkg::CTRL_SNOOP_OFF] &&
		!(pin_mode && snoop_s); // [R15] [R16]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_cnt <= amsc_pkg::LANE_CNT_RST;
			d3 <= 1'b0;
		end else if (aux_wr_valid && snoop_on && dp_mode) begin // [R12]
			if (aux_wr_addr == amsc_pkg::DPCD_LANE_COUNT)
				lane_cnt <= aux_wr_data[4:0]; // [R13]
			if (aux_wr_addr == amsc_pkg::DPCD_POWER_STATE)
				d3 <= aux_wr_data[2:0] == amsc_pkg::PWR_D3; // [R14]
		end
	end

	always_comb begin
		unique case (lane_cnt)
			5'h01: cnt_mask = 4'h1;
			5'h02: cnt_mask = 4'h3;
			default: cnt_mask = 4'hf;
		endcase
		if (snoop_on)
			next_lanes = d3 ? 4'h0 : cnt_mask; // [R13] [R14]
		else if (pin_mode && snoop_s)
			next_lanes = 4'hf; // [R16]
		else
			next_lanes = lanes_reg; // [R15]
		if (mode_q[3])
			next_lanes = next_lanes & 4'h3;
		else if (!mode_q[2])
			next_lanes = 4'h0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dp_lane_enable <= 4'h0;
		else
			dp_lane_enable <= next_lanes;
	end

	// Equalization: strap pairs or register override
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			usb_up_gain <= 4'h0;
			usb_dn_gain <= 4'h0;
			dp_gain <= 4'h0;
			usb_eq_enable <= 1'b0;
		end else begin
			usb_eq_enable <= !lfps_s; // [R8] [R9]
			if (ctrl[amsc_pkg::CTRL_GAIN_OVR]) begin
				usb_up_gain <= gain_reg[3:0]; // [R20]
				usb_dn_gain <= gain_reg[7:4];
				dp_gain <= gain_reg[11:8];
			end else begin
				usb_up_gain <= straps[5:2]; // [R19]
				usb_dn_gain <= straps[9:6];
				dp_gain <= straps[13:10];
			end
		end
	end

	// Receiver detection repeats each interval until a receiver answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxdet_cnt <= '0;
			rx_found <= 1'b0;
			rx_detect_start <= 1'b0;
			rx_term_enable <= 1'b0;
			redrive_ready <= 1'b0;
		end else begin
			rx_detect_start <= 1'b0;
			if (!usb_mode) begin
				rx_found <= 1'b0;
				rxdet_cnt <= '0;
			end else if (!rx_found) begin
				if (rxres_s)
					rx_found <= 1'b1; // [R10]
				if (rxdet_cnt == CW'(RXDET_CYC - 1)) begin
					rxdet_cnt <= '0;
					rx_detect_start <= 1'b1; // [R10]
				end else begin
					rxdet_cnt <= rxdet_cnt + CW'(1);
				end
			end
			rx_term_enable <= rx_found; // [R10]
			redrive_ready <= rx_found;
		end
	end

	// Link power state from line conditions, no traffic decode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt <= '0;
			usb_power_state <= amsc_pkg::ST_U3;
		end else if (!rx_found) begin
			idle_cnt <= '0;
			usb_power_state <= amsc_pkg::ST_U3; // [R11]
		end else if (!idle_s) begin
			idle_cnt <= '0;
			usb_power_state <= amsc_pkg::ST_U0; // [R11]
		end else if (!lfps_s) begin
			if (idle_cnt != CW'(U3_IDLE_CYC))
				idle_cnt <= idle_cnt + CW'(1);
			if (idle_cnt >= CW'(U3_IDLE_CYC))
				usb_power_state <= amsc_pkg::ST_U3;
			else if (idle_cnt >= CW'(U2_IDLE_CYC))
				usb_power_state <= amsc_pkg::ST_U2;
			else
				usb_power_state <= amsc_pkg::ST_U1; // [R11]
		end
	end

	// Checks
	property p_pwrdn;
		@(posedge pclk) disable iff (!presetn)
		pin_mode && seen_edge && !deb_out[0] && !mode_select_low_s
		|=> switch_mode == amsc_pkg::MODE_PWRDN;
	endproperty
	a_pwrdn: assert property (p_pwrdn) else $error("no power down"); // [R2]
	property p_usb;
		@(posedge pclk) disable iff (!presetn)
		pin_mode && seen_edge && !deb_out[0] && mode_select_low_s
		|=> switch_mode == amsc_pkg::MODE_USB && switch_flip == $past(flip_s);
	endproperty
	a_usb: assert property (p_usb) else $error("usb mode wrong"); // [R3]
	property p_dp4;
		@(posedge pclk) disable iff (!presetn)
		pin_mode && seen_edge && deb_out[0] && !mode_select_low_s
		|=> switch_mode == amsc_pkg::MODE_DP4;
	endproperty
	a_dp4: assert property (p_dp4) else $error("dp4 mode wrong"); // [R4]
	property p_dp2;
		@(posedge pclk) disable iff (!presetn)
		pin_mode && seen_edge && deb_out[0] && mode_select_low_s
		|=> switch_mode == amsc_pkg::MODE_USB_DP2 ##1
		dp_lane_enable[3:2] == 2'b00;
	endproperty
	a_dp2: assert property (p_dp2) else $error("usb dp2 wrong"); // [R5]
	property p_default;
		@(posedge pclk) disable iff (!presetn)
		pin_mode && !seen_edge |=> switch_mode == amsc_pkg::MODE_USB;
	endproperty
	a_default: assert property (p_default) else $error("no usb default"); // [R6]
	property p_lfps;
		@(posedge pclk) disable iff (!presetn)
		lfps_s[*2] |-> !usb_eq_enable;
	endproperty
	a_lfps: assert property (p_lfps) else $error("eq on during lfps"); // [R8]
	property p_d3;
		@(posedge pclk) disable iff (!presetn)
		aux_wr_valid && snoop_on && dp_mode && mode_q == next_mode &&
		aux_wr_addr == amsc_pkg::DPCD_POWER_STATE &&
		aux_wr_data[2:0] == amsc_pkg::PWR_D3 ##1 snoop_on
		|=> dp_lane_enable == 4'h0;
	endproperty
	a_d3: assert property (p_d3) else $error("lanes on in d3"); // [R14]
	property p_strap_snoop;
		@(posedge pclk) disable iff (!presetn)
		pin_mode && snoop_s && mode_q == amsc_pkg::MODE_DP4
		|=> dp_lane_enable == 4'hf;
	endproperty
	a_strap_snoop: assert property (p_strap_snoop) else $error("not 4 lanes"); // [R16]
	property p_aux_open;
		@(posedge pclk) disable iff (!presetn)
		$fell(alt_s) |=> aux_to_sb_straight || aux_to_sb_crossed;
	endproperty
	a_aux_open: assert property (p_aux_open) else $error("early open"); // [R23]
	property p_pull;
		@(posedge pclk) disable iff (!presetn)
		hold_cnt == 8'(amsc_pkg::STRAP_HOLD_CYC) |=> !strap_pull_enable;
	endproperty
	a_pull: assert property (p_pull) else $error("pulls not off"); // [R18]
	c_dp4: cover property (@(posedge pclk) switch_mode == amsc_pkg::MODE_DP4);
	c_d3: cover property (@(posedge pclk) dp_mode && d3);
	c_found: cover property (@(posedge pclk) $rose(rx_found));
	c_open: cover property (@(posedge pclk) $fell(aux_to_sb_straight));
endmodule

// ### design/amsc_pkg.sv
// Constants and types for the alternate-mode switch control block
package amsc_pkg;
	localparam int CLK_MHZ = 125;
	// Strap pull resistors stay on for this long after reset release
	localparam int STRAP_HOLD_US = 1;
	localparam int STRAP_HOLD_CYC = STRAP_HOLD_US * CLK_MHZ;
	// Straps pass two sync stages before the latch samples them
	localparam int STRAP_LATCH_CYC = 3;
	// High-to-low debounce, inside the 2 to 10 ms window
	localparam int DEBOUNCE_US = 2000;
	localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
	localparam int RXDET_MS = 12;
	localparam int RXDET_CYC = RXDET_MS * 1000 * CLK_MHZ;
	localparam int U2_IDLE_US = 100;
	localparam int U2_IDLE_CYC = U2_IDLE_US * CLK_MHZ;
	localparam int U3_IDLE_US = 1000;
	localparam int U3_IDLE_CYC = U3_IDLE_US * CLK_MHZ;
	localparam int CNT_W = 22;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LANES = 8'h04;
	localparam logic [7:0] REG_GAIN = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_STRAPS = 8'h10;
	// Control register fields
	localparam int CTRL_SNOOP_OFF = 0;
	localparam int CTRL_GAIN_OVR = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_FLIP = 4;
	localparam logic [4:0] CTRL_RST = 5'h04;
	localparam logic [3:0] LANES_RST = 4'hf;
	localparam logic [11:0] GAIN_RST = 12'h000;
	// Sink configuration fields whose writes are watched on the AUX channel
	localparam logic [19:0] DPCD_LANE_COUNT = 20'h00101;
	localparam logic [19:0] DPCD_POWER_STATE = 20'h00600;
	localparam logic [2:0] PWR_D3 = 3'h2;
	localparam logic [4:0] LANE_CNT_RST = 5'h04;
	// Four-level pin codes
	localparam logic [1:0] LVL_0 = 2'h0;
	localparam logic [1:0] LVL_R = 2'h1;
	localparam logic [1:0] LVL_F = 2'h2;
	localparam logic [1:0] LVL_1 = 2'h3;
	typedef enum logic [3:0] {
		MODE_PWRDN = 4'h1,
		MODE_USB = 4'h2,
		MODE_DP4 = 4'h4,
		MODE_USB_DP2 = 4'h8
	} amsc_mode_e;
	typedef enum logic [3:0] {
		ST_U0 = 4'h1,
		ST_U1 = 4'h2,
		ST_U2 = 4'h4,
		ST_U3 = 4'h8
	} amsc_ustate_e;
endpackage

// ### sim/amsc_pd_model.sv
// Power-delivery controller model driving the switch's mode pins
`timescale 1ns/100ps
module amsc_pd_model #(
	parameter int OVERLAP_CYC = 500
) (
	// Clock
	input wire logic pclk,
	// Pins to the switch
	output logic alt_mode_select,
	output logic mode_select_low,
	output logic plug_flip,
	output logic hot_plug_input
);
	initial begin
		alt_mode_select = 1'b0;
		mode_select_low = 1'b0;
		plug_flip = 1'b0;
		hot_plug_input = 1'b0;
	end
	// Swapping both selects goes through both-high, so no power-down glitch
	task automatic set_pins(input logic alt, input logic msl, input logic fl);
		@(posedge pclk);
		if (alt != alt_mode_select && msl != mode_select_low) begin
			alt_mode_select <= 1'b1;
			mode_select_low <= 1'b1;
			repeat (OVERLAP_CYC) @(posedge pclk);
		end
		alt_mode_select <= alt;
		mode_select_low <= msl;
		plug_flip <= fl;
	endtask
	// Low-high-low pulse releases the default USB mode
	task automatic leave_default();
		set_pins(1'b0, 1'b1, plug_flip);
		repeat (8) @(posedge pclk);
		set_pins(1'b0, 1'b0, plug_flip);
	endtask
	task automatic set_hpd(input logic v);
		@(posedge pclk);
		hot_plug_input <= v;
	endtask
endmodule

// ### sim/amsc_top_tb.sv
// Self-checking bench for the alternate-mode switch control block
`timescale 1ns/100ps
module amsc_top_tb;
	logic pclk = 1'b0, presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er;
	logic snoop_disable_strap = 1'b0;
	logic [1:0] host_bus_cfg_strap = amsc_pkg::LVL_0;
	logic [3:0] rx_gain_pins = 4'h6;
	logic [3:0] usb_path_gain_pins = 4'h9;
	logic [3:0] dp_path_gain_pins = 4'hc;
	logic lfps_detect = 1'b0, elec_idle = 1'b1, rx_detect_result = 1'b0;
	logic aux_wr_valid = 1'b0;
	logic [19:0] aux_wr_addr = 20'h0;
	logic [7:0] aux_wr_data = 8'h00;
	logic alt_mode_select, mode_select_low, plug_flip, hot_plug_input;
	logic strap_pull_enable, rx_detect_start, rx_term_enable;
	logic redrive_ready, usb_eq_enable, switch_flip, hot_plug_level;
	logic aux_to_sb_straight, aux_to_sb_crossed;
	logic [3:0] usb_up_gain, usb_dn_gain, dp_gain, usb_power_state;
	logic [3:0] switch_mode, dp_lane_enable;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;

	// Shortened counts keep the run to about a thousand cycles
	amsc_top #(.DEBOUNCE_CYC(20), .RXDET_CYC(16), .U2_IDLE_CYC(8),
		.U3_IDLE_CYC(20)) u_amsc_top (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .alt_mode_select, .mode_select_low,
		.plug_flip, .hot_plug_input, .snoop_disable_strap,
		.host_bus_cfg_strap, .rx_gain_pins, .usb_path_gain_pins,
		.dp_path_gain_pins, .strap_pull_enable, .lfps_detect, .elec_idle,
		.rx_detect_result, .rx_detect_start, .rx_term_enable,
		.redrive_ready, .usb_eq_enable, .usb_up_gain, .usb_dn_gain,
		.dp_gain, .usb_power_state, .aux_wr_valid, .aux_wr_addr,
		.aux_wr_data, .switch_mode, .switch_flip, .dp_lane_enable,
		.aux_to_sb_straight, .aux_to_sb_crossed, .hot_plug_level
	);
	amsc_pd_model u_amsc_pd_model (
		.pclk, .alt_mode_select, .mode_select_low, .plug_flip,
		.hot_plug_input
	);

	always #4 pclk = ~pclk;

	task automatic end_sim();
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			err_count++;
			$display("[ERR] %0t no pready", $time);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic t_straps();
		chk(strap_pull_enable, 1'b1, "pulls on");
		wait_cyc(130);
		chk(strap_pull_enable, 1'b0, "pulls off");
		chk(switch_mode, amsc_pkg::MODE_USB, "default mode");
		apb(1'b0, amsc_pkg::REG_STRAPS, 32'h0);
		chk(rd, {18'h0, 4'hc, 4'h9, 4'h6, amsc_pkg::LVL_0}, "straps");
		apb(1'b0, amsc_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h4, "ctrl reset");
		apb(1'b0, amsc_pkg::REG_LANES, 32'h0);
		chk(rd, 32'hf, "lanes reset");
		apb(1'b0, 8'h20, 32'h0);
		chk(er, 1'b1, "unmapped err");
		chk(rd, 32'h0, "unmapped data");
	endtask

	task automatic t_hpd();
		u_amsc_pd_model.set_hpd(1'b1);
		wait_cyc(5);
		chk(hot_plug_level, 1'b1, "hpd rise");
		u_amsc_pd_model.set_hpd(1'b0);
		wait_cyc(12);
		chk(hot_plug_level, 1'b1, "hpd held");
		wait_cyc(20);
		chk(hot_plug_level, 1'b0, "hpd fall");
	endtask

	task automatic t_usb();
		int n;
		n = 0;
		repeat (40) begin
			@(posedge pclk);
			if (rx_detect_start === 1'b1) n++;
		end
		chk(n > 1, 1'b1, "detect repeats");
		rx_detect_result <= 1'b1;
		wait_cyc(40);
		chk({rx_term_enable, redrive_ready}, 2'b11, "rx found");
		elec_idle <= 1'b0;
		wait_cyc(6);
		chk(usb_power_state, amsc_pkg::ST_U0, "U0");
		elec_idle <= 1'b1;
		wait_cyc(5);
		chk(usb_power_state, amsc_pkg::ST_U1, "U1");
		wait_cyc(11);
		chk(usb_power_state, amsc_pkg::ST_U2, "U2");
		wait_cyc(14);
		chk(usb_power_state, amsc_pkg::ST_U3, "U3");
		chk({usb_up_gain, usb_dn_gain, dp_gain}, 12'h69c, "pin gains");
		chk(usb_eq_enable, 1'b1, "eq on");
		lfps_detect <= 1'b1;
		wait_cyc(5);
		chk(usb_eq_enable, 1'b0, "eq off");
		lfps_detect <= 1'b0;
		apb(1'b1, amsc_pkg::REG_GAIN, 32'h321);
		apb(1'b1, amsc_pkg::REG_CTRL, 32'h6);
		wait_cyc(5);
		chk({usb_up_gain, usb_dn_gain, dp_gain}, 12'h123, "reg gains");
		chk(usb_eq_enable, 1'b1, "eq back");
		apb(1'b1, amsc_pkg::REG_CTRL, 32'h4);
	endtask

	// Entry: pins alt,msl,flip / mode / lanes / straight,crossed
	task automatic t_modes();
		logic [12:0] tbl [7];
		tbl = '{13'h0880, 13'h0c80, 13'h1a0e, 13'h1e0d, 13'h153d,
			13'h113e, 13'h0040};
		u_amsc_pd_model.leave_default();
		wait_cyc(10);
		chk(switch_mode, amsc_pkg::MODE_PWRDN, "left default");
		apb(1'b0, amsc_pkg::REG_STATUS, 32'h0);
		chk(rd[15], 1'b1, "pin mode");
		foreach (tbl[i]) begin
			u_amsc_pd_model.set_pins(tbl[i][12], tbl[i][11], tbl[i][10]);
			wait_cyc(50);
			chk({switch_mode, switch_flip, dp_lane_enable, aux_to_sb_straight,
				aux_to_sb_crossed}, {tbl[i][9:6], tbl[i][10], tbl[i][5:0]},
				"mode table");
		end
	endtask

	task automatic aux_chk(input logic [19:0] a, input logic [7:0] d,
		input logic [3:0] exp);
		@(posedge pclk);
		aux_wr_valid <= 1'b1;
		aux_wr_addr <= a;
		aux_wr_data <= d;
		@(posedge pclk);
		aux_wr_valid <= 1'b0;
		wait_cyc(3);
		chk(dp_lane_enable, exp, "lanes");
	endtask

	task automatic t_snoop();
		u_amsc_pd_model.set_pins(1'b1, 1'b0, 1'b0);
		wait_cyc(10);
		aux_chk(amsc_pkg::DPCD_LANE_COUNT, 8'h1, 4'h1);
		aux_chk(amsc_pkg::DPCD_LANE_COUNT, 8'h2, 4'h3);
		aux_chk(20'h00102, 8'h1, 4'h3);
		aux_chk(amsc_pkg::DPCD_POWER_STATE, 8'h2, 4'h0);
		aux_chk(amsc_pkg::DPCD_POWER_STATE, 8'h1, 4'h3);
		apb(1'b1, amsc_pkg::REG_LANES, 32'h5);
		apb(1'b1, amsc_pkg::REG_CTRL, 32'h5);
		aux_chk(amsc_pkg::DPCD_LANE_COUNT, 8'h1, 4'h5);
		apb(1'b1, amsc_pkg::REG_CTRL, 32'h4);
		aux_chk(amsc_pkg::DPCD_LANE_COUNT, 8'h2, 4'h3);
		snoop_disable_strap <= 1'b1;
		wait_cyc(4);
		aux_chk(amsc_pkg::DPCD_LANE_COUNT, 8'h1, 4'hf);
		snoop_disable_strap <= 1'b0;
	endtask

	// Register control needs a fresh strap latch, hence a second reset
	task automatic t_regmode();
		host_bus_cfg_strap <= amsc_pkg::LVL_F;
		rx_gain_pins <= 4'h1;
		usb_path_gain_pins <= 4'he;
		dp_path_gain_pins <= 4'h7;
		do_reset();
		wait_cyc(140);
		apb(1'b0, amsc_pkg::REG_STRAPS, 32'h0);
		chk(rd, {18'h0, 4'h7, 4'he, 4'h1, amsc_pkg::LVL_F}, "straps 2");
		chk({usb_up_gain, usb_dn_gain, dp_gain}, 12'h1e7, "gains 2");
		apb(1'b1, amsc_pkg::REG_CTRL, 32'h1c);
		wait_cyc(4);
		chk({switch_mode, switch_flip}, {amsc_pkg::MODE_USB_DP2, 1'b1},
			"reg mode");
		apb(1'b0, amsc_pkg::REG_STATUS, 32'h0);
		chk({rd[15], rd[4:0]}, 6'h18, "reg status");
		apb(1'b1, amsc_pkg::REG_CTRL, 32'h08);
		wait_cyc(4);
		chk({switch_mode, switch_flip}, {amsc_pkg::MODE_DP4, 1'b0},
			"reg dp4");
		apb(1'b1, amsc_pkg::REG_CTRL, 32'h10);
		wait_cyc(4);
		chk({switch_mode, switch_flip}, {amsc_pkg::MODE_PWRDN, 1'b1},
			"reg pwrdn");
	endtask

	initial begin
		do_reset();
		t_straps();
		t_hpd();
		t_usb();
		t_modes();
		t_snoop();
		t_regmode();
		end_sim();
	end
endmodule
